// ==== core/cdih_top.sv ====
// digital input conditioning, dispatch and register slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// one input channel: debounce, invert, dispatch
module cdih_chan (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       sample,
    input  wire logic [7:0] deb_count,
    input  wire logic       invert,
    input  wire logic       level_mode,
    input  wire logic       assigned,
    input  wire logic       assign_evt,
    input  wire logic       inv_evt,
    input  wire logic       powerup_evt,
    output logic            call,
    output logic            level
);
    logic       cand_reg;
    logic [7:0] cnt_reg;
    logic       stable_reg;
    logic       stable_prev_reg;
    logic       call_reg;
    logic       level_reg;

    wire        agree     = (sample == cand_reg);
    wire [7:0]  cnt_next  = agree ? ((cnt_reg == 8'hff) ? cnt_reg : cnt_reg + 8'h01)
                                  : 8'h01;
    wire        settled   = (cnt_next >= deb_count);
    wire        edge_seen = (stable_reg != stable_prev_reg);
    wire        trig      = level_mode ? tick : edge_seen;
    wire        call_next = assign_evt | (assigned & (inv_evt | powerup_evt | trig));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cand_reg        <= 1'b0;
            cnt_reg         <= 8'h00;
            stable_reg      <= 1'b0;
            stable_prev_reg <= 1'b0;
        end else begin
            stable_prev_reg <= stable_reg;
            if (tick) begin
                cand_reg <= sample;
                cnt_reg  <= cnt_next;
                if (settled) begin
                    stable_reg <= sample;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            call_reg  <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            call_reg  <= call_next;
            level_reg <= stable_reg ^ invert;
        end
    end

    assign call  = call_reg;
    assign level = level_reg;
endmodule // cdih_chan

////////////////////////////////////////////////////////////////////////////////
// top: register slave and eight channels
module cdih_top #(
    parameter int NUM_CH = cdih_pkg::NUM_CH
) (
    input  wire logic                             core_clk,
    input  wire logic                             rst,
    input  wire logic [NUM_CH-1:0]                din,
    input  wire logic [cdih_pkg::ADDR_W-1:0]      avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [cdih_pkg::DATA_W-1:0]      avs_writedata,
    output logic      [cdih_pkg::DATA_W-1:0]      avs_readdata,
    output logic                                  avs_waitrequest,
    output logic      [NUM_CH-1:0]                handler_call,
    output logic      [NUM_CH-1:0]                handler_level,
    output logic      [NUM_CH*cdih_pkg::CODE_W-1:0] handler_code,
    output logic                                  drive_enable_ok,
    output logic                                  map_error
);
    logic [7:0]                  func_reg [NUM_CH];
    logic [7:0]                  deb_reg  [NUM_CH];
    logic [7:0]                  inv_reg  [NUM_CH];
    logic [7:0]                  ctrl_reg [NUM_CH];
    logic                        wait_reg;
    logic [cdih_pkg::DATA_W-1:0] rdata_reg;
    logic                        err_reg;
    logic                        en_reg;
    logic [cdih_pkg::TICK_W-1:0] tick_cnt_reg;
    logic                        dup;
    logic [7:0]                  rd_chan;
    logic [NUM_CH-1:0]           call_w;
    logic [NUM_CH-1:0]           level_w;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    localparam logic [cdih_pkg::TICK_W-1:0] TICK_LAST =
        cdih_pkg::TICK_W'(cdih_pkg::TICK_CYCLES - 1);

    wire       tick     = (tick_cnt_reg == TICK_LAST);
    wire       is_chan  = ~avs_address[cdih_pkg::GLOBAL_BIT];
    wire [2:0] ch_idx   = avs_address[cdih_pkg::CH_MSB:cdih_pkg::CH_LSB];
    wire [1:0] sel      = avs_address[cdih_pkg::SEL_MSB:cdih_pkg::SEL_LSB];
    wire [7:0] wbyte    = avs_writedata[7:0];
    wire       wr_go    = avs_write & ~wait_reg;
    wire       rd_take  = avs_read & wait_reg;
    wire       wr_cfg   = wr_go & is_chan & (sel == cdih_pkg::SEL_CFG);
    wire       wr_deb   = wr_go & is_chan & (sel == cdih_pkg::SEL_DEB);
    wire       wr_inv   = wr_go & is_chan & (sel == cdih_pkg::SEL_INV);
    wire       wr_ctrl  = wr_go & is_chan & (sel == cdih_pkg::SEL_CTRL);
    wire       wr_stat  = wr_go & (avs_address == cdih_pkg::OFS_STATUS);
    wire       wr_pwr   = wr_go & (avs_address == cdih_pkg::OFS_POWERUP);
    wire       pwr_evt  = wr_pwr & avs_writedata[cdih_pkg::PWR_NVM_BIT];
    wire       conflict = dup & (wbyte != cdih_pkg::FUNC_NULL);
    wire       cfg_ok   = wr_cfg & ~conflict;
    wire       err_set  = wr_cfg & conflict;
    wire       err_clr  = wr_stat & avs_writedata[cdih_pkg::STAT_ERR_BIT];
    wire       err_next = (err_reg & ~err_clr) | err_set;

    // same code on any other channel
    always_comb begin
        dup = 1'b0;
        for (int j = 0; j < NUM_CH; j++) begin
            if ((3'(j) != ch_idx) && (func_reg[j] == wbyte)) begin
                dup = 1'b1;
            end
        end
    end

    always_comb begin
        rd_chan = 8'h00;
        case (sel)
            cdih_pkg::SEL_CFG:  rd_chan = func_reg[ch_idx];
            cdih_pkg::SEL_DEB:  rd_chan = deb_reg[ch_idx];
            cdih_pkg::SEL_INV:  rd_chan = inv_reg[ch_idx];
            cdih_pkg::SEL_CTRL: rd_chan = ctrl_reg[ch_idx];
            default:            rd_chan = 8'h00;
        endcase
    end

    wire [cdih_pkg::DATA_W-1:0] stat_word = {30'h0, en_reg, err_reg};
    wire [cdih_pkg::DATA_W-1:0] lvl_word  = {{(cdih_pkg::DATA_W-NUM_CH){1'b0}}, level_w};
    wire [cdih_pkg::DATA_W-1:0] rd_mux    =
        is_chan                               ? {24'h0, rd_chan} :
        (avs_address == cdih_pkg::OFS_STATUS) ? stat_word :
        (avs_address == cdih_pkg::OFS_LEVELS) ? lvl_word  : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle per access
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg <= ~((avs_read | avs_write) & wait_reg);
            if (rd_take) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings, error, enable, tick
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int k = 0; k < NUM_CH; k++) begin
                func_reg[k] <= cdih_pkg::CFG_RST;
                deb_reg[k]  <= cdih_pkg::DEB_RST;
                inv_reg[k]  <= cdih_pkg::INV_RST;
                ctrl_reg[k] <= cdih_pkg::CTRL_RST;
            end
        end else begin
            for (int k = 0; k < NUM_CH; k++) begin
                if (3'(k) == ch_idx) begin
                    if (cfg_ok)  func_reg[k] <= wbyte;
                    if (wr_deb)  deb_reg[k]  <= wbyte;
                    if (wr_inv)  inv_reg[k]  <= wbyte;
                    if (wr_ctrl) ctrl_reg[k] <= wbyte;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            err_reg      <= 1'b0;
            en_reg       <= 1'b0;
            tick_cnt_reg <= '0;
        end else begin
            err_reg      <= err_next;
            en_reg       <= din[0];
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channels
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire sel_me     = (ch_idx == 3'(g));
            wire assigned   = (func_reg[g] != cdih_pkg::FUNC_NULL);
            // only on assignment from FUNC_NULL, never when an assigned code is changed
            wire assign_evt = cfg_ok & sel_me & ~assigned
                              & (wbyte != cdih_pkg::FUNC_NULL);
            wire inv_evt    = wr_inv & sel_me & (wbyte != inv_reg[g]);

            cdih_chan u_chan (
                .core_clk    (core_clk),
                .rst         (rst),
                .tick        (tick),
                .sample      (din[g]),
                .deb_count   (deb_reg[g]),
                .invert      (inv_reg[g] != 8'h00),
                .level_mode  (ctrl_reg[g][cdih_pkg::CTRL_LEVEL_BIT]),
                .assigned    (assigned),
                .assign_evt  (assign_evt),
                .inv_evt     (inv_evt),
                .powerup_evt (pwr_evt),
                .call        (call_w[g]),
                .level       (level_w[g])
            );
            assign handler_code[g*cdih_pkg::CODE_W +: cdih_pkg::CODE_W] = func_reg[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign handler_call    = call_w;
    assign handler_level   = level_w;
    assign drive_enable_ok = en_reg;
    assign map_error       = err_reg;
endmodule // cdih_top

// ==== core/cdih_pkg.sv ====
// constants for the configurable digital input handler
package cdih_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_CH = 8;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 8;

    ////////////////////////////////////////////////////////////////////////////
    // function codes and reset values
    localparam logic [7:0] FUNC_NULL = 8'h00;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] DEB_RST   = 8'h01;
    localparam logic [7:0] INV_RST   = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam int CTRL_LEVEL_BIT    = 0;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam int GLOBAL_BIT = 7;
    localparam int CH_MSB     = 6;
    localparam int CH_LSB     = 4;
    localparam int SEL_MSB    = 3;
    localparam int SEL_LSB    = 2;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] OFS_CFG   = 8'h00;
    localparam logic [7:0] OFS_DEB   = 8'h04;
    localparam logic [7:0] OFS_INV   = 8'h08;
    localparam logic [7:0] OFS_CTRL  = 8'h0c;
    localparam logic [1:0] SEL_CFG   = OFS_CFG[SEL_MSB:SEL_LSB];
    localparam logic [1:0] SEL_DEB   = OFS_DEB[SEL_MSB:SEL_LSB];
    localparam logic [1:0] SEL_INV   = OFS_INV[SEL_MSB:SEL_LSB];
    localparam logic [1:0] SEL_CTRL  = OFS_CTRL[SEL_MSB:SEL_LSB];
    localparam logic [7:0] OFS_STATUS  = 8'h80;
    localparam logic [7:0] OFS_LEVELS  = 8'h84;
    localparam logic [7:0] OFS_POWERUP = 8'h88;
    localparam int STAT_ERR_BIT  = 0;
    localparam int STAT_EN_BIT   = 1;
    localparam int PWR_NVM_BIT   = 0;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W         = 8;

endpackage

// ==== dv/cdih_top_properties.sv ====
// port assertions for the digital input handler
`timescale 1ns/1ps
module cdih_top_checker #(
    parameter int NUM_CH = cdih_pkg::NUM_CH
) (
    input wire logic                core_clk,
    input wire logic                rst,
    input wire logic [NUM_CH-1:0]   din,
    input wire logic [7:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_writedata,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic [NUM_CH-1:0]   handler_call,
    input wire logic [NUM_CH-1:0]   handler_level,
    input wire logic [NUM_CH*8-1:0] handler_code,
    input wire logic                drive_enable_ok,
    input wire logic                map_error
);
    logic [NUM_CH-1:0] code_nz;
    wire               wr_ok = avs_write && !avs_waitrequest;
    wire               rd_ok = avs_read && !avs_waitrequest;
    always_comb
        for (int k = 0; k < NUM_CH; k++)
            code_nz[k] = |handler_code[8*k +: 8];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    a_enable_tracks_pin: assert property ($past(!rst) |-> drive_enable_ok == $past(din[0]))
        else $error("drive enable not following pin");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_null_no_call: assert property ((handler_call & ~(code_nz | $past(code_nz))) == '0)
        else $error("call on unassigned input");
    a_error_cause: assert property ($rose(map_error) |-> $past(wr_ok) || $past(wr_ok, 2))
        else $error("mapping error without write");
    a_error_sticky: assert property (map_error && !(wr_ok && avs_address == cdih_pkg::OFS_STATUS
        && avs_writedata[0]) |=> map_error) else $error("mapping error dropped");
    a_status_read: assert property (rd_ok && avs_address == cdih_pkg::OFS_STATUS
        |-> avs_readdata[0] == $past(map_error)) else $error("status read wrong");
    a_levels_read: assert property (rd_ok && avs_address == cdih_pkg::OFS_LEVELS
        |-> avs_readdata[NUM_CH-1:0] == $past(handler_level)) else $error("levels read wrong");
    a_code_read: assert property (rd_ok && !avs_address[7] && avs_address[3:0] == 4'h0
        |-> avs_readdata == 32'($past(handler_code[8*avs_address[6:4] +: 8])))
        else $error("code read wrong");
    a_unmapped_zero: assert property (rd_ok && avs_address >= cdih_pkg::OFS_POWERUP
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_code_by_write: assert property ($changed(handler_code) && $past(!rst) |-> $past(wr_ok))
        else $error("code changed without write");
    a_powerup_all: assert property (wr_ok && avs_address == cdih_pkg::OFS_POWERUP
        && avs_writedata[0] |=> handler_call == code_nz) else $error("power-up calls wrong");
endmodule // cdih_top_checker

bind cdih_top cdih_top_checker #(.NUM_CH(NUM_CH)) chk_u (.core_clk(core_clk), .rst(rst),
    .din(din), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .handler_call(handler_call),
    .handler_level(handler_level), .handler_code(handler_code),
    .drive_enable_ok(drive_enable_ok), .map_error(map_error));

// ==== dv/cdih_switch_model.sv ====
// switch bank with contact bounce on each change
`timescale 1ns/1ps
module cdih_switch_model #(
    parameter int BOUNCE = 10
) (
    input  wire logic       core_clk,
    input  wire logic [7:0] target,
    output logic      [7:0] din
);
    logic [7:0] held_reg = 8'h00;
    logic [7:0] chg_reg = 8'h00;
    int         left = 0;
    initial din = 8'h00;
    always @(posedge core_clk) begin
        if (target != held_reg) begin
            chg_reg <= target ^ held_reg;
            held_reg <= target;
            left <= BOUNCE;
        end else if (left > 0) begin
            din <= din ^ chg_reg;
            left <= left - 1;
        end else
            din <= held_reg;
    end
endmodule // cdih_switch_model

// ==== dv/cdih_top_tb_top.sv ====
// self-checking bench for the digital input handler
`timescale 1ns/1ps
module cdih_top_tb_top;
    logic        core_clk = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
    logic [7:0]  avs_address = 8'h00, sw_target = 8'h00, din, handler_call, handler_level;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, drive_enable_ok, map_error;
    logic [63:0] handler_code;
    int          failures = 0, tests_run = 0, cycles = 0, n0;
    int          calls[8], exp_calls[8], exp_code[8];
    bit          exp_err;
    always #20 core_clk = ~core_clk;
    cdih_switch_model sw_u (.core_clk(core_clk), .target(sw_target), .din(din));
    cdih_top dut_u (.core_clk(core_clk), .rst(rst), .din(din), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .handler_call(handler_call), .handler_level(handler_level),
        .handler_code(handler_code), .drive_enable_ok(drive_enable_ok), .map_error(map_error));
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            report_and_stop();
        end
        for (int k = 0; k < 8; k++)
            if (!rst && handler_call[k] === 1'h1)
                calls[k] <= calls[k] + 1;
    end
    task automatic report_and_stop();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 20);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        chk("waitrequest", avs_waitrequest, 32'h0);
    endtask
    task automatic set_code(input int ch, input int code);
        bit clash = 0;
        for (int k = 0; k < 8; k++)
            if (k != ch && code != 0 && exp_code[k] == code)
                clash = 1;
        bus(1, 8'(ch * 16), 32'(code));
        if (clash)
            exp_err = 1;
        else begin
            if (exp_code[ch] == 0 && code != 0)
                exp_calls[ch]++;
            exp_code[ch] = code;
        end
    endtask
    task automatic chk_calls();
        repeat (3) @(posedge core_clk);
        chk("map_error", map_error, 32'(exp_err));
        for (int k = 0; k < 8; k++) begin
            chk("calls", calls[k], exp_calls[k]);
            chk("code", handler_code[8*k +: 8], exp_code[k]);
        end
    endtask
    task automatic sync5();
        int i = 0;
        while (handler_call[5] !== 1'h1 && i++ < 60)
            @(posedge core_clk);
        @(posedge core_clk);
        n0 = calls[5];
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hd81e));
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            bus(0, 8'h70 + 8'(4 * k), 32'h0);
            chk("reset", q, k == 1 ? 32'(cdih_pkg::DEB_RST) : 32'h0);
        end
        bus(0, 8'h8c, 32'h0);
        chk("unmapped", q, 32'h0);
        sw_target <= 8'h01;
        repeat (15) @(posedge core_clk);
        chk("enable", drive_enable_ok, 32'h1);
        repeat (60) @(posedge core_clk);
        repeat (40) begin
            set_code($urandom % 8, $urandom % 5);
            chk_calls();
            bus(1, cdih_pkg::OFS_STATUS, 32'h1);
            exp_err = 0;
        end
        set_code(3, 8'h21);
        bus(1, 8'h34, 32'h3);
        for (int t = 0; t < 2; t++) begin
            sw_target[3] <= ~sw_target[3];
            repeat (40) @(posedge core_clk);
            chk("early", handler_level[3], 32'(t));
            repeat (100) @(posedge core_clk);
            chk("level", handler_level[3], 32'(1 - t));
            exp_calls[3]++;
        end
        chk_calls();
        bus(1, 8'h38, 32'h1);
        exp_calls[3]++;
        chk_calls();
        chk("inverted", handler_level[3], 32'h1);
        bus(0, cdih_pkg::OFS_LEVELS, 32'h0);
        chk("levels read", q, 32'h09);
        bus(0, 8'h30, 32'h0);
        chk("code read", q, 32'h21);
        set_code(5, 0);
        bus(1, 8'h5c, 32'h1);
        set_code(5, 8'h22);
        sync5();
        repeat (250) @(posedge core_clk);
        chk("ticks", calls[5] - n0, 32'd10);
        sync5();
        bus(1, 8'h58, 32'h1);
        repeat (10) @(posedge core_clk);
        chk("invert call", calls[5] - n0, 32'h1);
        set_code(5, 0);
        repeat (30) @(posedge core_clk);
        exp_calls[5] = calls[5];
        set_code(0, 8'h23);
        bus(1, cdih_pkg::OFS_POWERUP, 32'h1);
        for (int k = 0; k < 8; k++)
            exp_calls[k] += int'(exp_code[k] != 0);
        chk_calls();
        bus(0, cdih_pkg::OFS_STATUS, 32'h0);
        chk("status enable", q[1], 32'h1);
        sw_target[0] <= 1'h0;
        repeat (15) @(posedge core_clk);
        chk("enable", drive_enable_ok, 32'h0);
        exp_calls[0]++;
        repeat (60) @(posedge core_clk);
        chk_calls();
        report_and_stop();
    end
endmodule // cdih_top_tb_top
